// ===== hw/rcr_map.svh
/*
 * Register offsets, field positions, reset values and timing counts
 * of the reset cause and memory remap block.
 * Assumes byte addresses on a 32-bit register port, data in bits 7:0.
 */
`ifndef RCR_MAP_SVH
`define RCR_MAP_SVH

// -----------------------------------------------------------------------
// Register offsets
// -----------------------------------------------------------------------
`define RCR_MAP_SEL_OFF    32'hFFFF0220
`define RCR_CAUSE_STA_OFF  32'hFFFF0230
`define RCR_CAUSE_CLR_OFF  32'hFFFF0234
`define RCR_INT_STA_OFF    32'hFFFF0238
`define RCR_INT_MSK_OFF    32'hFFFF023C

// -----------------------------------------------------------------------
// Field positions and reset values
// -----------------------------------------------------------------------
`define RCR_MAP_SRAM_BIT   0
`define RCR_MAP_SRAM4K_BIT 3
`define RCR_MAP_FL32K_BIT  4
`define RCR_CAUSE_POR_BIT  0
`define RCR_CAUSE_WDT_BIT  1
`define RCR_CAUSE_SW_BIT   2
`define RCR_CAUSE_RST      3'h1
`define RCR_INT_WDT_BIT    0
`define RCR_INT_SW_BIT     1
`define RCR_INT_EXT_BIT    2
`define RCR_INT_BOOT_BIT   3
`define RCR_RESET_VECTOR   32'h00000000

// -----------------------------------------------------------------------
// Timing: hold and kernel times in ns, clock period in ps, least times rounded up to cycles
// -----------------------------------------------------------------------
`define RCR_CLK_PERIOD_PS  25000
`define RCR_HOLD_TIME_NS   250
`define RCR_KERN_TIME_NS   1000
`define RCR_HOLD_CYC  ((`RCR_HOLD_TIME_NS * 1000 + `RCR_CLK_PERIOD_PS - 1) \
                       / `RCR_CLK_PERIOD_PS)
`define RCR_KERN_CYC  ((`RCR_KERN_TIME_NS * 1000 + `RCR_CLK_PERIOD_PS - 1) \
                       / `RCR_CLK_PERIOD_PS)

`endif

// ===== hw/rcr_pkg.sv
/*
 * Types of the reset cause and memory remap block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package rcr_pkg;

    // Sequencer states.
    typedef enum logic [1:0] {
        ST_HOLD   = 2'b00,
        ST_KERNEL = 2'b01,
        ST_RUN    = 2'b10,
        ST_LOADER = 2'b11
    } rcr_state_type;

    // One register port request.
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [31:0] addr;
        logic [7:0]  wdata;
    } rcr_req_type;

endpackage : rcr_pkg

// ===== hw/rcr_top.sv
/*
 * Reset cause recorder, reset sequencer and low-memory mirror select.
 * Assumes RST_B is the power-on reset, all inputs are synchronous to
 * CLOCK, and the watchdog timeout is a one-cycle pulse.
 */
`timescale 1ns/1ps
`include "rcr_map.svh"

module rcr_top
    import rcr_pkg::*;
#(
    parameter bit FLASH_32K = 1'b0,
    parameter bit SRAM_4K   = 1'b0
) (
    // Clock and power-on reset
    input  wire logic        CLOCK,
    input  wire logic        RST_B,
    // Register port
    input  wire logic [31:0] ADDR,
    input  wire logic [31:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [31:0] RDATA,
    // Reset sources and boot strap
    input  wire logic        WDT_TIMEOUT,
    input  wire logic        EXT_RESET_B,
    input  wire logic        BOOT_MODE_PIN,
    // System control
    output logic             SYS_RESET_B,
    output logic             KERNEL_ACTIVE,
    output logic             CORE_START,
    output logic      [31:0] BOOT_VECTOR,
    output logic             LOW_MIRROR_SRAM,
    // Interrupt
    output logic             IRQ
);

    // -------------------------------------------------------------------
    // Address decode
    // -------------------------------------------------------------------

    // Matches a bus address against one register offset.
    function automatic logic hit(input logic [31:0] a,
                                 input logic [31:0] off);
        return a == off;
    endfunction : hit

    rcr_req_type   req;
    rcr_state_type state_q;
    rcr_state_type state_d;
    logic [7:0]    cnt_q;
    logic [7:0]    cnt_d;
    logic          remap_q;
    logic          remap_d;
    logic [2:0]    cause_q;
    logic [2:0]    cause_d;
    logic [2:0]    cause_set;
    logic [3:0]    ist_q;
    logic [3:0]    ist_d;
    logic [3:0]    ist_set;
    logic [3:0]    imsk_q;
    logic          ext_q;
    logic          start_q;
    logic [31:0]   rdata_q;
    logic [31:0]   rdata_d;
    wire           wr_map;
    wire           wr_sta;
    wire           wr_clr;
    wire           wr_ist;
    wire           wr_msk;
    wire           sw_req;
    wire           ext_low;
    wire           reset_req;
    wire           hold_done;
    wire           kern_done;
    wire [7:0]     map_rd;

    // Bus request bundle and write strobes per register.
    assign req    = '{wr: WR, rd: RD, addr: ADDR, wdata: WDATA[7:0]};
    assign wr_map = req.wr && hit(req.addr, `RCR_MAP_SEL_OFF);
    assign wr_sta = req.wr && hit(req.addr, `RCR_CAUSE_STA_OFF);
    assign wr_clr = req.wr && hit(req.addr, `RCR_CAUSE_CLR_OFF);
    assign wr_ist = req.wr && hit(req.addr, `RCR_INT_STA_OFF);
    assign wr_msk = req.wr && hit(req.addr, `RCR_INT_MSK_OFF);

    // -------------------------------------------------------------------
    // Reset sources
    // -------------------------------------------------------------------

    // Watchdog, external pin and software write all restart the system.
    assign sw_req    = wr_sta && req.wdata[`RCR_CAUSE_SW_BIT];
    assign ext_low   = !EXT_RESET_B;
    assign reset_req = WDT_TIMEOUT || ext_low || sw_req;

    // Cause flags; the external pin sets none, and a set beats a clear.
    assign cause_set = {sw_req, WDT_TIMEOUT, 1'b0};
    assign cause_d   = (cause_q & ~(wr_clr ? req.wdata[2:0] : 3'h0))
                     | cause_set;

    // Power-on reset leaves only the power-on flag set.
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            cause_q <= `RCR_CAUSE_RST;
        end else begin
            cause_q <= cause_d;
        end
    end

    // -------------------------------------------------------------------
    // Reset sequencer
    // -------------------------------------------------------------------

    assign hold_done = cnt_q == 8'(`RCR_HOLD_CYC - 1);
    assign kern_done = cnt_q == 8'(`RCR_KERN_CYC - 1);

    // Holds the system in reset, runs the kernel, then starts the core, or enters the loader when BOOT_MODE_PIN is low.
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q + 8'h01;
        if (reset_req) begin
            state_d = ST_HOLD;
            cnt_d   = 8'h00;
        end else begin
            unique case (state_q)
                ST_HOLD: begin
                    if (hold_done) begin
                        state_d = ST_KERNEL;
                        cnt_d   = 8'h00;
                    end
                end
                ST_KERNEL: begin
                    if (kern_done) begin
                        state_d = BOOT_MODE_PIN ? ST_RUN : ST_LOADER;
                        cnt_d   = 8'h00;
                    end
                end
                ST_RUN: begin
                    cnt_d = 8'h00;
                end
                ST_LOADER: begin
                    cnt_d = 8'h00;
                end
            endcase
        end
    end

    // State, counter and the one-cycle jump pulse.
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            state_q <= ST_HOLD;
            cnt_q   <= 8'h00;
            start_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            start_q <= state_q == ST_KERNEL && state_d == ST_RUN;
        end
    end

    assign SYS_RESET_B   = state_q != ST_HOLD;
    assign KERNEL_ACTIVE = state_q == ST_KERNEL;
    assign CORE_START    = start_q;
    assign BOOT_VECTOR   = `RCR_RESET_VECTOR;

    // -------------------------------------------------------------------
    // Low memory mirror
    // -------------------------------------------------------------------

    // Software picks SRAM or flash; any reset forces flash back.
    assign remap_d = (reset_req || state_q == ST_HOLD) ? 1'b0
                   : wr_map ? req.wdata[`RCR_MAP_SRAM_BIT]
                   : remap_q;

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            remap_q <= 1'b0;
        end else begin
            remap_q <= remap_d;
        end
    end

    assign LOW_MIRROR_SRAM = remap_q;

    // Size flags are fixed by the part model and ignore writes.
    assign map_rd = {3'h0, FLASH_32K, SRAM_4K, 2'h0, remap_q};

    // -------------------------------------------------------------------
    // Interrupts
    // -------------------------------------------------------------------

    assign ist_set = {start_q, ext_low && !ext_q, sw_req, WDT_TIMEOUT};

    // Sticky event bits, cleared by writing one; a new event wins.
    for (genvar i = 0; i < 4; i++) begin : g_ist
        assign ist_d[i] = ist_set[i]
                        || (ist_q[i] && !(wr_ist && req.wdata[i]));
    end

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            ist_q  <= 4'h0;
            imsk_q <= 4'h0;
            ext_q  <= 1'b0;
        end else begin
            ist_q  <= ist_d;
            imsk_q <= wr_msk ? req.wdata[3:0] : imsk_q;
            ext_q  <= ext_low;
        end
    end

    assign IRQ = |(ist_q & imsk_q);

    // -------------------------------------------------------------------
    // Read data
    // -------------------------------------------------------------------

    // Read data stands for one cycle; the clear register reads zero.
    always_comb begin
        rdata_d = 32'h00000000;
        if (req.rd) begin
            if (hit(req.addr, `RCR_MAP_SEL_OFF)) begin
                rdata_d[7:0] = map_rd;
            end else if (hit(req.addr, `RCR_CAUSE_STA_OFF)) begin
                rdata_d[2:0] = cause_q;
            end else if (hit(req.addr, `RCR_INT_STA_OFF)) begin
                rdata_d[3:0] = ist_q;
            end else if (hit(req.addr, `RCR_INT_MSK_OFF)) begin
                rdata_d[3:0] = imsk_q;
            end
        end
    end

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            rdata_q <= 32'h00000000;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign RDATA = rdata_q;

    // -------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_B);

    a_remap_set_sram: assert property (
        wr_map && req.wdata[0] && !reset_req && state_q != ST_HOLD
        |=> LOW_MIRROR_SRAM)
        else $error("SRAM mirror not selected after write of one.");

    a_remap_back_flash: assert property (
        wr_map && !req.wdata[0] |=> !LOW_MIRROR_SRAM)
        else $error("Flash mirror not restored after write of zero.");

    a_reset_flash_map: assert property (
        reset_req |=> !LOW_MIRROR_SRAM && !SYS_RESET_B)
        else $error("Reset did not restore flash mirror.");

    a_wdt_cause_set: assert property (
        WDT_TIMEOUT |=> cause_q[1] && !SYS_RESET_B)
        else $error("Watchdog cause not recorded.");

    a_sw_reset_cause: assert property (
        sw_req |=> cause_q[2] ##1 !SYS_RESET_B)
        else $error("Software reset not recorded or not held.");

    a_clear_bit_zero: assert property (
        wr_clr && req.wdata[0] |=> !cause_q[0])
        else $error("Power-on cause not cleared.");

    a_clear_keeps_bit: assert property (
        wr_clr && !req.wdata[1] && cause_q[1] |=> cause_q[1])
        else $error("Cause bit lost on zero clear bit.");

    a_ext_no_flag: assert property (
        ext_low && !WDT_TIMEOUT && !sw_req && !wr_clr
        |=> cause_q == $past(cause_q))
        else $error("External reset changed a cause flag.");

    a_kernel_jump_run: assert property (
        state_q == ST_KERNEL && kern_done && BOOT_MODE_PIN && !reset_req
        |=> CORE_START && state_q == ST_RUN ##1 !CORE_START)
        else $error("Kernel did not jump to the reset vector.");

    a_size_bits_read: assert property (
        req.rd && hit(req.addr, `RCR_MAP_SEL_OFF)
        |=> RDATA[4] == FLASH_32K && RDATA[3] == SRAM_4K)
        else $error("Size flags read wrong.");

    c_sw_reset: cover property (sw_req ##[1:80] CORE_START);
    c_wdt_reset: cover property (WDT_TIMEOUT ##[1:80] CORE_START);
    c_remap_sram: cover property (wr_map && req.wdata[0] ##1 remap_q);
    c_loader: cover property (state_q == ST_LOADER);

endmodule : rcr_top

// ===== sim/rcr_src_model.sv
/*
 * Model of the reset sources beside the block: watchdog and reset pin.
 * Assumes the bench raises its requests just after a rising edge.
 */
`timescale 1ns/1ps

module rcr_src_model (
    // Clock and bench requests
    input  wire logic       clock,
    input  wire logic       wdt_go,
    input  wire logic       ext_go,
    input  wire logic [3:0] ext_len,
    // Reset source lines
    output logic            wdt_timeout = 1'b0,
    output logic            ext_reset_b
);
    // -------------------------------------------------------------------
    // Source lines
    // -------------------------------------------------------------------
    logic [3:0] ext_cnt_q = 4'h0;

    // Expiry is one cycle wide; the pin stays low for ext_len cycles.
    always_ff @(posedge clock) begin
        wdt_timeout <= wdt_go;
        if (ext_go) begin
            ext_cnt_q <= ext_len;
        end else if (ext_cnt_q != 4'h0) begin
            ext_cnt_q <= ext_cnt_q - 4'h1;
        end
    end

    // The pin has a pull-up, so it idles high between requests.
    assign ext_reset_b = (ext_cnt_q == 4'h0);
endmodule : rcr_src_model

// ===== sim/rcr_top_tb_top.sv
/*
 * Self-checking bench of the reset cause and remap block.
 * Assumes the block answers reads one cycle late and never stalls.
 */
`timescale 1ns/1ps
`include "rcr_map.svh"

module rcr_top_tb_top;
    // -------------------------------------------------------------------
    // Signals
    // -------------------------------------------------------------------
    localparam bit FL = 1'b1;
    localparam bit SR = 1'b0;
    logic        clock = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0;
    logic        boot = 1'b1, wdt_go = 1'b0, ext_go = 1'b0;
    logic [31:0] addr = 32'h0, wdata = 32'h0, rdata, bvec, cur;
    logic [31:0] seed = 32'hE90A;
    logic [3:0]  ext_len = 4'h3;
    logic        sys_b, kern, start, mirror, irq, wdt, ext_b;
    int          err_total = 0, cmp_count = 0, n, kc = 0;

    // Clock at 40 MHz.
    initial forever #12.5 clock = ~clock;

    rcr_top #(.FLASH_32K(FL), .SRAM_4K(SR)) dut_u (
        .CLOCK(clock), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata), .WDT_TIMEOUT(wdt),
        .EXT_RESET_B(ext_b), .BOOT_MODE_PIN(boot), .SYS_RESET_B(sys_b),
        .KERNEL_ACTIVE(kern), .CORE_START(start), .BOOT_VECTOR(bvec),
        .LOW_MIRROR_SRAM(mirror), .IRQ(irq));

    rcr_src_model src_u (
        .clock(clock), .wdt_go(wdt_go), .ext_go(ext_go),
        .ext_len(ext_len), .wdt_timeout(wdt), .ext_reset_b(ext_b));

    // -------------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    // Map select reads the size bits beside the mirror bit.
    function automatic logic [31:0] map_exp(input logic b);
        return {27'h0, FL, SR, 3'h0} | {31'h0, b};
    endfunction : map_exp

    // Ones in the clear value drop cause bits; zeros keep them.
    function automatic logic [31:0] clr_exp(input logic [31:0] c, v);
        return c & ~{29'h0, v[2:0]};
    endfunction : clr_exp

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
            err_total++;
        end
    endtask : chk

    task automatic report_and_stop;
        if (err_total == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
        @(posedge clock);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clock);
        wr <= 1'b0;
        #1;
    endtask : wr_reg

    // Read data stand only in the cycle after the strobe.
    task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
        @(posedge clock);
        rd <= 1'b1;
        addr <= a;
        @(posedge clock);
        rd <= 1'b0;
        #1 chk(rdata, e);
    endtask : rd_chk

    // Watchdog (w=1) or pin request; the core is held two cycles later.
    task automatic req(input logic w);
        @(posedge clock);
        if (w) wdt_go <= 1'b1; else ext_go <= 1'b1;
        @(posedge clock);
        wdt_go <= 1'b0;
        ext_go <= 1'b0;
        @(posedge clock);
        #1 chk(32'(sys_b), 32'h0);
    endtask : req

    task automatic wait_start;
        for (n = 0; n < 200 && start !== 1'b1; n++) begin
            @(posedge clock);
            #1;
        end
        if (start !== 1'b1) begin
            err_total++;
            report_and_stop();
        end
        @(posedge clock);
        #1;
    endtask : wait_start

    // -------------------------------------------------------------------
    // Scenarios
    // -------------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clock);
        rst_b <= 1'b1;
        #1 chk(32'(mirror), 32'h0);
        rd_chk(`RCR_CAUSE_STA_OFF, 32'h1);
        wait_start;
        chk(bvec, `RCR_RESET_VECTOR);
        rd_chk(`RCR_MAP_SEL_OFF, map_exp(1'b0));
        // The bench acts as software running from high flash here.
        for (int i = 0; i < 6; i++) begin
            seed = xs(seed);
            wr_reg(`RCR_MAP_SEL_OFF, seed);
            chk(32'(mirror), 32'(seed[0]));
            rd_chk(`RCR_MAP_SEL_OFF, map_exp(seed[0]));
        end
        wr_reg(`RCR_MAP_SEL_OFF, 32'h1);
        req(1'b1);
        chk(32'(mirror), 32'h0);
        rd_chk(`RCR_CAUSE_STA_OFF, 32'h3);
        wait_start;
        cur = 32'h3;
        wr_reg(`RCR_CAUSE_CLR_OFF, 32'h0);
        rd_chk(`RCR_CAUSE_STA_OFF, cur);
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            wr_reg(`RCR_CAUSE_CLR_OFF, seed);
            cur = clr_exp(cur, seed);
            rd_chk(`RCR_CAUSE_STA_OFF, cur);
        end
        rd_chk(`RCR_CAUSE_CLR_OFF, 32'h0);
        wr_reg(`RCR_MAP_SEL_OFF, 32'h1);
        wr_reg(`RCR_CAUSE_STA_OFF, 32'h4);
        chk(32'(sys_b), 32'h0);
        chk(32'(mirror), 32'h0);
        wait_start;
        rd_chk(`RCR_CAUSE_STA_OFF, cur | 32'h4);
        wr_reg(`RCR_CAUSE_CLR_OFF, 32'h7);
        rd_chk(`RCR_CAUSE_STA_OFF, 32'h0);
        wr_reg(`RCR_MAP_SEL_OFF, 32'h1);
        req(1'b0);
        chk(32'(mirror), 32'h0);
        wait_start;
        rd_chk(`RCR_CAUSE_STA_OFF, 32'h0);
        // Interrupt: every event seen so far, then mask and clear.
        rd_chk(`RCR_INT_STA_OFF, 32'hF);
        wr_reg(`RCR_INT_STA_OFF, 32'hF);
        wr_reg(`RCR_INT_MSK_OFF, 32'h1);
        chk(32'(irq), 32'h0);
        req(1'b1);
        wait_start;
        chk(32'(irq), 32'h1);
        wr_reg(`RCR_INT_MSK_OFF, 32'h0);
        chk(32'(irq), 32'h0);
        wr_reg(`RCR_INT_MSK_OFF, 32'h1);
        chk(32'(irq), 32'h1);
        wr_reg(`RCR_INT_STA_OFF, 32'h1);
        chk(32'(irq), 32'h0);
        // Unmapped place reads zero and takes no write.
        wr_reg(32'hFFFF0224, 32'hFF);
        rd_chk(32'hFFFF0224, 32'h0);
        rd_chk(`RCR_MAP_SEL_OFF, map_exp(1'b0));
        // Power-on reset while remapped, boot mode low: no start.
        wr_reg(`RCR_MAP_SEL_OFF, 32'h1);
        @(posedge clock);
        boot <= 1'b0;
        rst_b <= 1'b0;
        repeat (2) @(posedge clock);
        #1 chk(32'(mirror), 32'h0);
        @(posedge clock);
        rst_b <= 1'b1;
        cur = 32'h0;
        repeat (120) begin
            @(posedge clock);
            #1 if (start === 1'b1) cur++;
            if (kern === 1'b1) kc++;
        end
        chk(cur, 32'h0);
        chk(kc, `RCR_KERN_CYC);
        rd_chk(`RCR_CAUSE_STA_OFF, 32'h1);
        report_and_stop();
    end

    // Cut a hang short.
    initial begin
        #2250000;
        err_total++;
        report_and_stop();
    end
endmodule : rcr_top_tb_top
